// ---- src/srip_top.v ----
// scanning readout input port: polled sign-byte and status-only readout capture
// Contract
// - a sign-byte poll drives the request level high
// - request stays high until the instrument delivers a readout
// - not-ready sign poll disables host side, request stays, one readout still caught
// - ready sign poll sends plus 2B or minus 2D from the sign input
// - sign poll moves one byte; following input transfer delivers the rest
// - status-only poll reports ready state and moves no data
// - scanning mode starts on first poll, lasts until a readout arrives; the code clears it only as the last digit byte goes out to the host
// - five microseconds after strobe drop request; raise again on host ready
// - bytes go out as ASCII, sign first then digits
`timescale 1ns/1ps
`include "srip_defs.vh"
module srip_top
(
    // clock, reset, enable
    input  wire                    clock,
    input  wire                    nrst,
    input  wire                    ce,
    // host poll and transfer requests (one-cycle pulses, port taken as already selected)
    input  wire                    sign_byte_poll,
    input  wire                    status_poll,
    input  wire                    input_xfer,
    input  wire                    host_ready,
    // host answers
    output reg                     host_valid_q,
    output reg  [7:0]              host_data_q,
    output reg                     host_last_q,
    output reg                     status_valid_q,
    output reg                     status_ready_q,
    output reg                     host_enabled_q,
    output reg                     scan_mode_q,
    // instrument pins
    input  wire                    strobe_pin,
    input  wire                    sign_pin,
    input  wire [`SRIP_DATA_W-1:0] digit_pin,
    output reg                     request_q
);
    // hold-off count, already sized to the wait counter
    localparam [`SRIP_WAIT_W-1:0] WAIT_CYC = `SRIP_STROBE_WAIT_CYC;
    // request handshake states
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_WAIT = 2'd1;
    localparam [1:0] ST_HELD = 2'd2;
    localparam [1:0] ST_DONE = 2'd3;

    wire                    strobe_s;
    wire                    sign_s;
    wire [`SRIP_DATA_W-1:0] digit_s;
    reg                     strobe_prev_q;
    reg  [1:0]              state_q;
    reg  [`SRIP_WAIT_W-1:0] wait_q;
    reg                     data_ready_q;
    reg                     cap_sign_q;
    reg  [`SRIP_DATA_W-1:0] cap_digit_q;
    reg  [`SRIP_CNT_W-1:0]  byte_idx_q;
    reg                     sending_q;
    wire                    strobe_rise;
    wire [3:0]              cur_digit;

    // all instrument inputs cross clock domains through the filter
    srip_sync #(.W(1)) u_sync_strobe
    (
        .clock   (clock),
        .nrst    (nrst),
        .ce      (ce),
        .pin     (strobe_pin),
        .level_q (strobe_s)
    );
    srip_sync #(.W(`SRIP_DATA_W + 1)) u_sync_data
    (
        .clock   (clock),
        .nrst    (nrst),
        .ce      (ce),
        .pin     ({sign_pin, digit_pin}),
        .level_q ({sign_s, digit_s})
    );

    assign strobe_rise = strobe_s & ~strobe_prev_q;
    // digit 0 is the most significant nibble
    assign cur_digit = cap_digit_q[`SRIP_DATA_W-1 -: 4];

    // request handshake, capture and byte delivery
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            strobe_prev_q  <= 1'b0;
            state_q        <= ST_IDLE;
            wait_q         <= {`SRIP_WAIT_W{1'b0}};
            data_ready_q   <= 1'b0;
            cap_sign_q     <= 1'b0;
            cap_digit_q    <= {`SRIP_DATA_W{1'b0}};
            byte_idx_q     <= {`SRIP_CNT_W{1'b0}};
            sending_q      <= 1'b0;
            request_q      <= 1'b0;
            host_valid_q   <= 1'b0;
            host_data_q    <= 8'h00;
            host_last_q    <= 1'b0;
            status_valid_q <= 1'b0;
            status_ready_q <= 1'b0;
            host_enabled_q <= 1'b0;
            scan_mode_q    <= 1'b0;
        end
        else if (ce)
        begin
            strobe_prev_q  <= strobe_s;
            host_valid_q   <= 1'b0;
            host_last_q    <= 1'b0;
            status_valid_q <= 1'b0;
            // first poll of either kind enters scanning mode
            if (sign_byte_poll || status_poll)
                scan_mode_q <= 1'b1;
            // status poll answers ready state only, no data moves
            if (status_poll)
            begin
                status_valid_q <= 1'b1;
                status_ready_q <= data_ready_q;
                // arming here too lets a pure status scan still collect a readout
                if (!data_ready_q && state_q == ST_IDLE)
                    request_q <= 1'b1;
            end
            // sign poll: raise request, then answer or disable host side
            if (sign_byte_poll)
            begin
                if (!data_ready_q)
                begin
                    if (state_q == ST_IDLE)
                        request_q <= 1'b1;
                    host_enabled_q <= 1'b0;
                end
                else if (!sending_q)
                begin
                    host_enabled_q <= 1'b1;
                    host_valid_q   <= 1'b1;
                    host_data_q    <= cap_sign_q ? `SRIP_ASCII_MINUS : `SRIP_ASCII_PLUS;
                    byte_idx_q     <= 3'd1;
                end
            end
            // ordinary input transfer streams remaining bytes, sign first if not yet sent
            if (input_xfer && data_ready_q && !sending_q)
            begin
                sending_q      <= 1'b1;
                host_enabled_q <= 1'b1;
            end
            if (sending_q)
            begin
                host_valid_q <= 1'b1;
                if (byte_idx_q == 3'd0)
                begin
                    host_data_q <= cap_sign_q ? `SRIP_ASCII_MINUS : `SRIP_ASCII_PLUS;
                    byte_idx_q  <= 3'd1;
                end
                else
                begin
                    host_data_q <= {4'h3, cur_digit};
                    cap_digit_q <= {cap_digit_q[`SRIP_DATA_W-5:0], 4'h0};
                    byte_idx_q  <= byte_idx_q + 3'd1;
                    if (byte_idx_q == `SRIP_DIGITS)
                    begin
                        host_last_q  <= 1'b1;
                        sending_q    <= 1'b0;
                        data_ready_q <= 1'b0;
                        byte_idx_q   <= 3'd0;
                        scan_mode_q  <= sign_byte_poll | status_poll;
                    end
                end
            end
            // request handshake: strobe, 5 us hold-off, low while held, host ready re-arms
            case (state_q)
                ST_IDLE:
                begin
                    // capture even while host side is disabled; request held until then
                    if (strobe_rise && request_q && !data_ready_q)
                    begin
                        cap_sign_q   <= sign_s;
                        cap_digit_q  <= digit_s;
                        data_ready_q <= 1'b1;
                        byte_idx_q   <= 3'd0;
                        wait_q       <= WAIT_CYC - 10'd1;
                        state_q      <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (wait_q == {`SRIP_WAIT_W{1'b0}})
                    begin
                        request_q <= 1'b0;
                        state_q   <= ST_HELD;
                    end
                    else
                        wait_q <= wait_q - 10'd1;
                end
                ST_HELD:
                begin
                    // readout gone: a fresh poll re-arms at once instead of idling in done
                    if (!data_ready_q)
                        state_q <= ST_DONE;
                    if (!data_ready_q && (sign_byte_poll || status_poll))
                    begin
                        request_q <= 1'b1;
                        state_q   <= ST_IDLE;
                    end
                end
                ST_DONE:
                begin
                    // host ready after the transfer re-arms the request
                    // a new poll counts as the host being ready again
                    if (host_ready || sign_byte_poll || status_poll)
                    begin
                        request_q <= 1'b1;
                        state_q   <= ST_IDLE;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // srip_top

// ---- src/srip_defs.vh ----
// constants for the scanning readout input port
`ifndef SRIP_DEFS_VH
`define SRIP_DEFS_VH
`define SRIP_CLK_MHZ        125
`define SRIP_STROBE_WAIT_US 5
// 5 us at 125 MHz is 625 cycles, sized to the wait counter
`define SRIP_STROBE_WAIT_CYC 10'h271
`define SRIP_WAIT_W         10
`define SRIP_ASCII_PLUS     8'h2B
`define SRIP_ASCII_MINUS    8'h2D
`define SRIP_ASCII_ZERO     8'h30
`define SRIP_DIGITS         3'h4
`define SRIP_DATA_W         16
`define SRIP_CNT_W          3
`endif

// ---- src/srip_sync.v ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module srip_sync
#(
    parameter W = 1
)
(
    // clock and reset
    input  wire         clock,
    input  wire         nrst,
    input  wire         ce,
    // pin side and synchronised level
    input  wire [W-1:0] pin,
    output reg  [W-1:0] level_q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    // first stage feeds only the second; level moves once stages two and three agree
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q    <= {W{1'b0}};
            s2_q    <= {W{1'b0}};
            s3_q    <= {W{1'b0}};
            level_q <= {W{1'b0}};
        end
        else if (ce)
        begin
            s1_q    <= pin;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
        end
    end
endmodule // srip_sync

// ---- dv/srip_top_asserts.sv ----
// concurrent checks on the scanning readout input port
`timescale 1ns/1ps
module srip_top_asserts
(
    // clock and reset
    input wire logic       clock,
    input wire logic       nrst,
    // host side
    input wire logic       ce,
    input wire logic       sign_byte_poll,
    input wire logic       status_poll,
    input wire logic       host_valid_q,
    input wire logic [7:0] host_data_q,
    input wire logic       host_last_q,
    input wire logic       status_valid_q,
    input wire logic       scan_mode_q,
    // instrument side
    input wire logic       strobe_pin,
    input wire logic       request_q
);
    logic [9:0] since_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // cycles since the strobe pin rose; saturates so an old strobe never wraps round
    always @(posedge clock)
    begin
        if (!nrst)
            since_q <= 10'h3ff;
        else if ($rose(strobe_pin))
            since_q <= 10'h000;
        else if (ce && since_q != 10'h3ff)
            since_q <= since_q + 10'h001;
    end
    a_first_poll: assert property ((sign_byte_poll || status_poll) && ce && !scan_mode_q
        |=> scan_mode_q && request_q) else $error("poll did not start scanning");
    a_status_ans: assert property (status_poll && ce |=> status_valid_q && !host_valid_q)
        else $error("status poll answer wrong");
    a_sign_code: assert property ($past(sign_byte_poll && ce) && host_valid_q
        |-> host_data_q == 8'h2B || host_data_q == 8'h2D) else $error("sign byte code wrong");
    a_one_sign: assert property ($past(sign_byte_poll && ce) && host_valid_q && ce
        |=> !host_valid_q) else $error("sign poll moved more than one byte");
    a_ascii_byte: assert property (host_valid_q |-> host_data_q == 8'h2B || host_data_q == 8'h2D
        || (host_data_q[7:4] == 4'h3 && host_data_q[3:0] <= 4'h9)) else $error("byte not ascii");
    a_last_valid: assert property (host_last_q |-> host_valid_q && host_data_q[7:4] == 4'h3)
        else $error("last flag without digit byte");
    a_scan_clear: assert property (host_last_q && !$past(sign_byte_poll || status_poll)
        |-> !scan_mode_q) else $error("scan mode kept after readout");
    a_req_drop: assert property ($fell(request_q) |-> since_q >= 10'h26c && since_q <= 10'h285)
        else $error("request dropped at wrong time");
    a_ce_freeze: assert property (!ce |=> $stable(request_q) && $stable(scan_mode_q)
        && $stable(host_valid_q) && $stable(status_valid_q)) else $error("state moved while ce low");
endmodule // srip_top_asserts

// ---- dv/srip_instr.sv ----
// instrument model: answers a raised request level with one strobed readout
`timescale 1ns/1ps
module srip_instr
(
    // clock and control from the bench
    input  wire logic        clock,
    input  wire logic        request,
    input  wire logic        go,
    input  wire logic [3:0]  dly,
    input  wire logic        sign_in,
    input  wire logic [15:0] digits_in,
    // instrument pins
    output logic             strobe,
    output logic             sign,
    output logic [15:0]      digits
);
    // data held while request is high, inverted after so no stale readout lingers
    initial
    begin
        strobe = 1'b0;
        sign = 1'b1;
        digits = 16'hffff;
        forever
        begin
            @(negedge clock);
            if (go && request)
            begin
                sign = sign_in;
                digits = digits_in;
                repeat (dly + 2) @(negedge clock);
                strobe = 1'b1;
                repeat (6) @(negedge clock);
                strobe = 1'b0;
                wait (!request);
                @(negedge clock);
                sign = ~sign;
                digits = ~digits;
            end
        end
    end
endmodule // srip_instr

// ---- dv/tb.sv ----
// self-checking bench for the scanning readout input port
`timescale 1ns/1ps
`include "srip_defs.vh"
module tb;
    logic        clock, nrst, ce, sign_byte_poll, status_poll, input_xfer, host_ready, go, sg_r;
    logic        host_valid_q, host_last_q, status_valid_q, status_ready_q, host_enabled_q;
    logic        scan_mode_q, request_q, strobe_pin, sign_pin;
    logic [7:0]  host_data_q;
    logic [15:0] dg_r, digit_pin;
    logic [31:0] rnd;
    logic [8:0]  exp_q[$];
    int          n_errors, compares, cyc, n, k;
    srip_top srip_top_i (.clock, .nrst, .ce, .sign_byte_poll, .status_poll, .input_xfer,
        .host_ready, .host_valid_q, .host_data_q, .host_last_q, .status_valid_q, .status_ready_q,
        .host_enabled_q, .scan_mode_q, .strobe_pin, .sign_pin, .digit_pin, .request_q);
    srip_instr srip_instr_i (.clock(clock), .request(request_q), .go(go), .dly(rnd[7:4]),
        .sign_in(sg_r), .digits_in(dg_r), .strobe(strobe_pin), .sign(sign_pin), .digits(digit_pin));
    function logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task chk(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // host poll of either kind; no address travels, the port is taken as already selected
    task poll(input logic st);
        @(negedge clock);
        status_poll = st;
        sign_byte_poll = !st;
        @(negedge clock);
        status_poll = 1'b0;
        sign_byte_poll = 1'b0;
    endtask
    // 8 ns clock, with a cycle ceiling that cuts a hang short
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            print_verdict;
        end
    end
    // every host byte is matched against the oldest expected note
    always @(negedge clock)
    begin
        if (host_valid_q !== 1'b0)
        begin
            if (exp_q.size() == 0)
                chk(host_valid_q, 9'h000);
            else
                chk({host_last_q, host_data_q}, exp_q.pop_front());
        end
    end
    initial
    begin
        {nrst, sign_byte_poll, status_poll, input_xfer, host_ready, go, sg_r} = 7'h00;
        ce = 1'b1;
        dg_r = 16'h0000;
        rnd = 32'h0000_4e59;
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        for (int it = 0; it < 2; it++)
        begin
            rnd = xs(rnd);
            sg_r = rnd[0];
            for (k = 0; k < 4; k++)
                dg_r[k*4+:4] = 4'((rnd >> (8 * k + 1)) % 10);
            poll(1'b0);
            chk(request_q, 9'h001);
            chk(host_enabled_q, 9'h000);
            poll(1'b1);
            chk(status_valid_q, 9'h001);
            chk(status_ready_q, 9'h000);
            chk(request_q, 9'h001);
            go = 1'b1;
            for (n = 0; strobe_pin !== 1'b1 && n < 100; n++) @(negedge clock);
            go = 1'b0;
            n = 0;
            do
            begin
                poll(1'b1);
                n++;
            end
            while (status_ready_q !== 1'b1 && n < 50);
            chk(status_ready_q, 9'h001);
            chk(scan_mode_q, 9'h001);
            exp_q.push_back({1'b0, sg_r ? `SRIP_ASCII_MINUS : `SRIP_ASCII_PLUS});
            poll(1'b0);
            chk(host_enabled_q, 9'h001);
            for (k = 3; k >= 0; k--)
                exp_q.push_back({k == 0, `SRIP_ASCII_ZERO | {4'h0, dg_r[k*4+:4]}});
            @(negedge clock);
            input_xfer = 1'b1;
            @(negedge clock);
            input_xfer = 1'b0;
            for (n = 0; exp_q.size() != 0 && n < 20; n++) @(negedge clock);
            @(negedge clock);
            chk(scan_mode_q, 9'h000);
            // ce low freezes the block, so a status poll then is not taken
            ce = 1'b0;
            poll(1'b1);
            chk(status_valid_q, 9'h000);
            chk(scan_mode_q, 9'h000);
            ce = 1'b1;
            for (n = 0; request_q === 1'b1 && n < 1000; n++) @(negedge clock);
            repeat (3) @(negedge clock);
            chk(request_q, 9'h000);
            // first pass re-arms by host ready, second by a fresh status poll
            if (it == 0)
            begin
                host_ready = 1'b1;
                @(negedge clock);
                host_ready = 1'b0;
            end
            else
                poll(1'b1);
            repeat (3) @(negedge clock);
            chk(request_q, 9'h001);
        end
        chk(9'(exp_q.size()), 9'h000);
        print_verdict;
    end
endmodule // tb
bind srip_top srip_top_asserts srip_top_asserts_i (.clock(clock), .nrst(nrst), .ce(ce),
    .sign_byte_poll(sign_byte_poll), .status_poll(status_poll), .host_valid_q(host_valid_q),
    .host_data_q(host_data_q), .host_last_q(host_last_q), .status_valid_q(status_valid_q),
    .scan_mode_q(scan_mode_q), .strobe_pin(strobe_pin), .request_q(request_q));
